// ===== common/amp_regs_defines.svh
`ifndef AMP_REGS_DEFINES_SVH
`define AMP_REGS_DEFINES_SVH

// Register offsets on the control port
`define OFS_RIGHT_VOLUME 8'h05
`define OFS_ANALOG_CONTROL 8'h06
`define OFS_RESERVED_SLOT 8'h07
`define OFS_FAULT_CONFIG_STATUS 8'h08

// Reset values
`define RST_RIGHT_VOLUME 8'hcf
`define RST_ANALOG_CONTROL 8'h51
`define RST_OC_THRESHOLD 2'h0

// Volume coding
`define VOL_UNITY_CODE 9'h0cf
`define VOL_MUTE_BELOW 8'h07

// Analog control field positions
`define AC_BIT7 7
`define AC_RATE_HI 6
`define AC_RATE_LO 4
`define AC_GAIN_HI 3
`define AC_GAIN_LO 2
`define AC_SLOT 1
`define AC_BIT0 0

// Fault register field positions
`define FC_THR_HI 5
`define FC_THR_LO 4
`define FC_CLOCK 3

// Switching rate multiples of the frame rate
`define MULT_CODE0 5'h06
`define MULT_CODE1 5'h08
`define MULT_CODE2 5'h0a
`define MULT_CODE3 5'h0c
`define MULT_CODE4 5'h0e
`define MULT_CODE5 5'h10
`define MULT_CODE6 5'h14
`define MULT_CODE7 5'h18

// Overcurrent threshold in percent of nominal
`define OC_PCT_CODE0 7'h64
`define OC_PCT_CODE1 7'h4b
`define OC_PCT_CODE2 7'h32
`define OC_PCT_CODE3 7'h19

`endif

// ===== common/amp_regs_pkg.sv
`default_nettype none
package amp_regs_pkg;

	// Analog control register layout
	typedef struct packed {
		logic mustBeOne;
		logic [2:0] switchRate;
		logic [1:0] analogGain;
		logic slotSelect;
		logic keepOne;
	} analog_control_type;

	// Latched fault events: overcurrent, dc offset, overtemperature
	typedef struct packed {
		logic overcurrent;
		logic dcOffset;
		logic overtemp;
	} fault_event_type;

	// Host register access
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wrData;
	} reg_access_type;

endpackage
`default_nettype wire

// ===== logic/amp_volume_analog_fault_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_defines.svh"

module amp_volume_analog_fault_regs
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire amp_regs_pkg::reg_access_type regAccess,
	input wire logic speedModeBit,
	input wire logic clockFaultIn,
	input wire amp_regs_pkg::fault_event_type faultEvent,
	input wire logic amp_shutdown_n,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic [7:0] rightVolume,
	output logic signed [9:0] rightGainHalfDb,
	output logic rightMute,
	output logic [4:0] switchMultiple,
	output logic [1:0] analogGain,
	output logic slotSelect,
	output logic [6:0] overcurrentPct,
	output amp_regs_pkg::fault_event_type faultLatched,
	output logic clockFaultFlag,
	output logic ampHalt
);
	import amp_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Switching multiple of the frame rate for a rate code
	function automatic logic [4:0] rateMultiple(input logic [2:0] code);
		logic [4:0] m;
		m = `MULT_CODE5;
		case (code)
			3'h0: m = `MULT_CODE0;
			3'h1: m = `MULT_CODE1;
			3'h2: m = `MULT_CODE2;
			3'h3: m = `MULT_CODE3;
			3'h4: m = `MULT_CODE4;
			3'h5: m = `MULT_CODE5;
			3'h6: m = `MULT_CODE6;
			3'h7: m = `MULT_CODE7;
			default: m = `MULT_CODE5;
		endcase
		return m;
	endfunction

	// Overcurrent threshold percentage for a threshold code
	function automatic logic [6:0] thresholdPct(input logic [1:0] code);
		logic [6:0] p;
		p = `OC_PCT_CODE0;
		case (code)
			2'h0: p = `OC_PCT_CODE0;
			2'h1: p = `OC_PCT_CODE1;
			2'h2: p = `OC_PCT_CODE2;
			2'h3: p = `OC_PCT_CODE3;
			default: p = `OC_PCT_CODE0;
		endcase
		return p;
	endfunction

	// Write strobe for one offset
	function automatic logic writeHit(input reg_access_type a, input logic [7:0] ofs);
		return a.write && (a.addr == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Control registers

	logic [7:0] rightVolume_q;
	analog_control_type analog_q;
	logic [1:0] ocThreshold_q;
	logic shutdownPrev_q;
	fault_event_type faultLatched_q;
	logic clockFault_q;

	// Right volume, full eight bits writable
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			rightVolume_q <= `RST_RIGHT_VOLUME;
		else if (writeHit(regAccess, `OFS_RIGHT_VOLUME))
			rightVolume_q <= regAccess.wrData;
	end

	// Analog control; stored as written, the host owns bits 7 and 0
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			analog_q <= `RST_ANALOG_CONTROL;
		else if (writeHit(regAccess, `OFS_ANALOG_CONTROL))
			analog_q <= regAccess.wrData;
	end

	// Only the threshold field of the fault register is writable
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			ocThreshold_q <= `RST_OC_THRESHOLD;
		else if (writeHit(regAccess, `OFS_FAULT_CONFIG_STATUS))
			ocThreshold_q <= regAccess.wrData[`FC_THR_HI:`FC_THR_LO];
	end

	////////////////////////////////////////////////////////////////////////
	// Fault tracking

	// Previous shutdown level, for spotting the rising half of a toggle
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			shutdownPrev_q <= 1'b1;
		else
			shutdownPrev_q <= amp_shutdown_n;
	end

	// Clock fault simply follows the detector, no latch
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			clockFault_q <= 1'b0;
		else
			clockFault_q <= clockFaultIn;
	end

	// Latched faults: cleared while shutdown is low, a new event wins so none is lost
	// Each flag owns its flip-flop; the packed copy is only wiring, one driver per bit
	genvar gi;
	generate
		for (gi = 0; gi < $bits(fault_event_type); gi++)
		begin : gLatch
			logic flag_q;

			always_ff @(posedge mclk)
			begin
				if (!reset_n)
					flag_q <= 1'b0;
				else if (faultEvent[gi])
					flag_q <= 1'b1;
				else if (!amp_shutdown_n)
					flag_q <= 1'b0;
			end

			assign faultLatched_q[gi] = flag_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Register read port; answer one cycle after the request

	logic [7:0] readMux;

	// Same-cycle read and write of one offset returns the old value
	// Reserved bits and the reserved offset read as zero
	always_comb
	begin
		readMux = 8'h00;
		case (regAccess.addr)
			`OFS_RIGHT_VOLUME: readMux = rightVolume_q;
			`OFS_ANALOG_CONTROL: readMux = analog_q;
			`OFS_RESERVED_SLOT: readMux = 8'h00;
			`OFS_FAULT_CONFIG_STATUS: readMux = {2'b00, ocThreshold_q, clockFault_q,
				faultLatched_q};
			default: readMux = 8'h00;
		endcase
	end

	// Read data with its one-cycle valid pulse; data is zero outside the pulse
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rdData <= 8'h00;
			rdValid <= 1'b0;
		end
		else
		begin
			rdData <= regAccess.read ? readMux : 8'h00;
			rdValid <= regAccess.read;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded controls toward the amplifier, all registered

	logic [4:0] multSel;
	logic [9:0] volWide;

	// Pure decode wires feeding the output flip-flops
	assign multSel = rateMultiple(analog_q.switchRate);
	assign volWide = {2'b00, rightVolume_q};

	// Registered copy of the stored volume code
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			rightVolume <= `RST_RIGHT_VOLUME;
		else
			rightVolume <= rightVolume_q;
	end

	// Gain in half-dB steps around the unity code; mute codes still get a value
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			rightGainHalfDb <= 10'sh000;
		else
			rightGainHalfDb <= $signed(volWide - {1'b0, `VOL_UNITY_CODE});
	end

	// Codes below the last attenuation step silence the channel outright
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			rightMute <= 1'b0;
		else
			rightMute <= (rightVolume_q < `VOL_MUTE_BELOW);
	end

	// Double speed halves the multiple so the switching period stays put
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			switchMultiple <= `MULT_CODE5;
		else
			switchMultiple <= speedModeBit ? {1'b0, multSel[4:1]} : multSel;
	end

	// Gain code passed on unchecked; the host keeps clear of the reserved code
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			analogGain <= 2'h0;
		else
			analogGain <= analog_q.analogGain;
	end

	// Slot choice only matters in software control mode
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			slotSelect <= 1'b0;
		else
			slotSelect <= analog_q.slotSelect;
	end

	// Threshold as a percentage of the nominal level
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			overcurrentPct <= `OC_PCT_CODE0;
		else
			overcurrentPct <= thresholdPct(ocThreshold_q);
	end

	// Status copy of the latched flags
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			faultLatched <= 3'b000;
		else
			faultLatched <= faultLatched_q;
	end

	// Clock fault mirrors the detector, no latch
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			clockFaultFlag <= 1'b0;
		else
			clockFaultFlag <= clockFault_q;
	end

	// Halt lifts one cycle after shutdown returns high, so a short toggle still shows
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			ampHalt <= 1'b0;
		else
			ampHalt <= (|faultLatched_q) || clockFault_q || !shutdownPrev_q;
	end

endmodule

`default_nettype wire

// ===== bench/amp_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Output timing against host writes and fault inputs
module amp_regs_monitor
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire amp_regs_pkg::reg_access_type regAccess,
	input wire logic speedModeBit,
	input wire logic clockFaultIn,
	input wire amp_regs_pkg::fault_event_type faultEvent,
	input wire logic amp_shutdown_n,
	input wire logic rdValid,
	input wire logic [7:0] rightVolume,
	input wire logic signed [9:0] rightGainHalfDb,
	input wire logic rightMute,
	input wire logic [4:0] switchMultiple,
	input wire amp_regs_pkg::fault_event_type faultLatched,
	input wire logic clockFaultFlag
);
	import amp_regs_pkg::*;
	localparam logic [4:0] MULT [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	//////////
	// Write strobes; decoded outputs follow two edges later
	sequence wrVol;
		regAccess.write && regAccess.addr == 8'h05;
	endsequence
	sequence wrAna;
		regAccess.write && regAccess.addr == 8'h06;
	endsequence
	read_pulse_a: assert property (rdValid == $past(regAccess.read))
		else $error("read pulse");
	vol_store_a: assert property (wrVol |=> ##1 rightVolume == $past(regAccess.wrData, 2))
		else $error("volume");
	gain_code_a: assert property (rightGainHalfDb == 10'(rightVolume) - 10'd207)
		else $error("gain");
	mute_low_a: assert property (rightMute == (rightVolume < 8'h07))
		else $error("mute");
	rate_map_a: assert property (wrAna |=> ##1
		switchMultiple == MULT[$past(regAccess.wrData[6:4], 2)] >> $past(speedModeBit))
		else $error("rate");
	clock_follow_a: assert property (clockFaultFlag == $past(clockFaultIn, 2))
		else $error("clock flag");
	fault_set_a: assert property (faultEvent.overcurrent |-> ##2 faultLatched.overcurrent)
		else $error("fault set");
	fault_hold_a: assert property (amp_shutdown_n && $past(amp_shutdown_n)
		&& faultLatched.dcOffset |=> faultLatched.dcOffset) else $error("fault hold");
endmodule
bind amp_volume_analog_fault_regs amp_regs_monitor mon
(
	.mclk(mclk),
	.reset_n(reset_n),
	.regAccess(regAccess),
	.speedModeBit(speedModeBit),
	.clockFaultIn(clockFaultIn),
	.faultEvent(faultEvent),
	.amp_shutdown_n(amp_shutdown_n),
	.rdValid(rdValid),
	.rightVolume(rightVolume),
	.rightGainHalfDb(rightGainHalfDb),
	.rightMute(rightMute),
	.switchMultiple(switchMultiple),
	.faultLatched(faultLatched),
	.clockFaultFlag(clockFaultFlag)
);
`default_nettype wire

// ===== bench/amp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the control port; offset 0x07 is never addressed
module amp_host_model
(
	input wire logic mclk,
	input wire logic rdValid,
	input wire logic [7:0] rdData,
	output amp_regs_pkg::reg_access_type regAccess
);
	import amp_regs_pkg::*;
	initial regAccess = '0;
	//////////
	// One-cycle strobe, dropped at the next edge
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) regAccess <= '{wr, !wr, a, d};
		@(posedge mclk) regAccess <= '0;
	endtask
	// Data caught mid-cycle while its pulse stands; a missed pulse leaves unknown
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		d = 8'hxx;
		access(1'b0, a, 8'h00);
		repeat (2)
		begin
			@(negedge mclk);
			if (rdValid === 1'b1)
				d = rdData;
		end
	endtask
endmodule
`default_nettype wire

// ===== bench/amp_volume_analog_fault_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h %h", $time, a, e); end end
module amp_volume_analog_fault_regs_tb_top;
	import amp_regs_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic speedModeBit = 1'b0;
	logic clockFaultIn = 1'b0;
	logic amp_shutdown_n = 1'b1;
	fault_event_type faultEvent = '0;
	reg_access_type regAccess;
	logic rdValid, rightMute, slotSelect, clockFaultFlag, ampHalt;
	logic [7:0] rdData, rightVolume, rd;
	logic signed [9:0] rightGainHalfDb;
	logic [4:0] switchMultiple;
	logic [1:0] analogGain;
	logic [6:0] overcurrentPct;
	fault_event_type faultLatched;
	int miscompares = 0;
	int checked = 0;
	localparam logic [4:0] MULT [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
	//////////
	// Clock, block and host wired by name
	always #5 mclk = ~mclk;
	amp_volume_analog_fault_regs uut (.*);
	amp_host_model host (.*);
	// Covers the longest path: shutdown release to halt drop
	task automatic settle();
		repeat (4) @(posedge mclk);
	endtask
	// Reset code, both ends of the range and the mute edge
	task automatic checkVol();
		logic [7:0] v [5] = '{8'hff, 8'hfe, 8'h07, 8'h06, 8'h00};
		`CHK({rightVolume, rightGainHalfDb}, {8'hcf, 10'h000})
		foreach (v[i])
		begin
			host.access(1'b1, 8'h05, v[i]);
			settle();
			`CHK({rightGainHalfDb, rightMute}, {10'(v[i]) - 10'd207, v[i] < 8'h07})
		end
		host.read(8'h05, rd);
		`CHK(rd, 8'h00)
	endtask
	// Every rate code in both speeds; gain code 11 is never sent
	task automatic checkAna();
		host.read(8'h06, rd);
		`CHK({rd, switchMultiple}, {8'h51, 5'h10})
		for (int c = 0; c < 16; c++)
		begin
			@(posedge mclk) speedModeBit <= c[3];
			host.access(1'b1, 8'h06, {1'b1, c[2:0], 2'(c % 3), c[0], 1'b1});
			settle();
			`CHK(switchMultiple, MULT[c[2:0]] >> c[3])
			`CHK({analogGain, slotSelect}, {2'(c % 3), c[0]})
		end
	endtask
	// Threshold codes, ignored flag bits, clock fault, latched faults
	task automatic checkFault();
		for (int t = 0; t < 4; t++)
		begin
			host.access(1'b1, 8'h08, {2'h3, t[1:0], 4'hf});
			settle();
			host.read(8'h08, rd);
			`CHK({rd, overcurrentPct}, {2'h0, t[1:0], 4'h0, 7'(100 - 25 * t)})
		end
		@(posedge mclk) clockFaultIn <= 1'b1;
		settle();
		host.read(8'h08, rd);
		`CHK({clockFaultFlag, ampHalt, rd[3:0]}, {2'h3, 4'h8})
		@(posedge mclk) clockFaultIn <= 1'b0;
		settle();
		`CHK({clockFaultFlag, ampHalt}, 2'h0)
		for (int f = 0; f < 3; f++)
		begin
			@(posedge mclk) faultEvent <= 3'(1 << f);
			@(posedge mclk) faultEvent <= '0;
			settle();
			host.read(8'h08, rd);
			`CHK({rd[3:0], faultLatched, ampHalt}, {1'b0, 3'(1 << f), 3'(1 << f), 1'b1})
			@(posedge mclk) amp_shutdown_n <= 1'b0;
			@(posedge mclk) amp_shutdown_n <= 1'b1;
			settle();
			`CHK({faultLatched, ampHalt}, 4'h0)
		end
	endtask
	// Reset for five cycles, then each scenario in turn
	initial
	begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		checkVol();
		checkAna();
		checkFault();
		report_and_stop();
	end
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
endmodule
`default_nettype wire
